// file: hdl/nts_sequencer.sv
`timescale 1ns/1ps
`include "nts_map.svh"
module nts_sequencer #(
    parameter int MS_CYCLES = `NTS_MS_NS / `NTS_CLK_NS
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // Register port
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    // Frame source
    input  wire logic        i_tx_req,
    input  wire logic        i_tx_data,
    input  wire logic        i_tx_last,
    input  wire logic        i_tx_more,
    output logic             o_tx_take,
    // Equipment pins
    input  wire logic        i_dce_clk,
    input  wire logic        i_net_busy,
    output logic             o_key,
    output logic             o_tx_bit,
    // Access timing events
    output logic             o_lag_end,
    output logic             o_turn_end,
    output logic             o_hold_done,
    output logic             o_timeout_done,
    output logic             o_access_done
);
    nts_pkg::nts_regs_t r;
    nts_pkg::nts_regs_t n;
    logic        bit_en;
    logic        phase_over;
    logic        mtt_over;
    logic [15:0] turn_abs;
    logic [15:0] turn;
    logic [15:0] lag_less;
    logic [15:0] tol_eff;
    logic [15:0] ack_eff;
    logic [15:0] proc_eff;
    logic [15:0] ack_data;
    logic [15:0] ack_bits;
    logic [23:0] ack_num;
    logic        hold_run;
    logic        tmo_run;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    // Clamp written values to their legal ranges
    function automatic logic [15:0] nts_limit(input logic [3:0]  idx,
                                              input logic [15:0] v);
        logic [15:0] m;
        m = 16'hFFFF;
        if (idx == `NTS_P_PRE)
            m = `NTS_PRE_MAX;
        else if (idx == `NTS_P_PHASE)
            m = `NTS_PHASE_MAX;
        else if (idx == `NTS_P_DTURN)
            m = `NTS_DTURN_MAX;
        nts_limit = (v > m) ? m : v;
    endfunction

    // bit pacing from equipment or local divider
    // Sync mode paces on the sampled equipment clock, else local divider
    assign bit_en = r.ctrl[`NTS_C_SYNC] ? (r.dclk2 & ~r.dclk_prev)
                                        : (r.div_cnt == 16'h0000);
    assign phase_over = r.ctrl[`NTS_C_PACKET] ||
                        (r.ms_el >= r.par[`NTS_P_PHASE]);
    // Zero limit means no concatenation limit applies
    assign mtt_over = (r.par[`NTS_P_MAXTX] != 16'h0000) &&
                      (r.key_ms >= r.par[`NTS_P_MAXTX]);

    assign turn_abs = (r.par[`NTS_P_TXTURN] > r.par[`NTS_P_RXTURN]) ?
                      r.par[`NTS_P_TXTURN] : r.par[`NTS_P_RXTURN];
    assign turn = (turn_abs > r.par[`NTS_P_LAG]) ?
                  turn_abs - r.par[`NTS_P_LAG] : 16'h0000;
    // tolerance floor, unknown smallest lag reads 0
    assign lag_less = (r.par[`NTS_P_LAG] > r.par[`NTS_P_SMALL]) ?
                      r.par[`NTS_P_LAG] - r.par[`NTS_P_SMALL] : 16'h0000;
    assign tol_eff = (r.par[`NTS_P_TOLER] > lag_less) ?
                     r.par[`NTS_P_TOLER] : lag_less;
    assign ack_eff = (r.par[`NTS_P_ACK] > turn) ? r.par[`NTS_P_ACK] : turn;
    assign proc_eff = (r.par[`NTS_P_PROC] > turn) ?
                      r.par[`NTS_P_PROC] : turn;

    // ack data portion by coding
    // Dispersive coding alone is not a listed case and counts as plain
    assign ack_data = !r.ctrl[`NTS_C_FEC] ? `NTS_D_PLAIN :
                      (r.ctrl[`NTS_C_DISP] ? `NTS_D_BOTH : `NTS_D_FEC);
    assign ack_bits = `NTS_SYNC_BITS + `NTS_HDR_BITS + ack_data +
                      (r.ctrl[`NTS_C_IND] ? `NTS_IND_BITS : 16'h0000);
    assign ack_num = 24'(ack_bits * `NTS_MS_PER_S) +
                     {9'h000, r.par[`NTS_P_RATE][15:1]};

    // Next state of the whole block, apart from the millisecond timers
    always_comb
    begin
        n = r;
        n.tick = 1'b0;
        n.take = 1'b0;
        n.lag_end = 1'b0;
        n.turn_end = 1'b0;
        n.clr = 1'b0;
        n.div_go = 1'b0;
        n.rdata = 32'h00000000;
        // Two-stage synchronisers for the equipment pins
        n.dclk1 = i_dce_clk;
        n.dclk2 = r.dclk1;
        n.dclk_prev = r.dclk2;
        n.busy1 = i_net_busy;
        n.busy2 = r.busy1;
        if (r.ms_cnt == 18'(MS_CYCLES - 1))
        begin
            n.ms_cnt = 18'h00000;
            n.tick = 1'b1;
        end
        else
        begin
            n.ms_cnt = r.ms_cnt + 18'h00001;
        end
        if (r.tick && r.ms_el != 16'hFFFF)
            n.ms_el = r.ms_el + 16'h0001;
        if (r.tick && r.key && r.key_ms != 16'hFFFF)
            n.key_ms = r.key_ms + 16'h0001;
        // Local bit clock, idle while unkeyed
        if (!r.key || r.div_cnt == 16'h0000)
            n.div_cnt = r.par[`NTS_P_BITDIV];
        else
            n.div_cnt = r.div_cnt - 16'h0001;

        // Register writes; parameters clamp to range
        if (i_wr)
        begin
            if (i_addr == `NTS_A_CTRL)
            begin
                n.ctrl = i_wdata[4:0];
                n.clr = i_wdata[`NTS_C_CLR];
                n.div_go = 1'b1;
            end
            else if (i_addr[7:6] == `NTS_A_PAR_WIN)
            begin
                n.par[i_addr[5:2]] = nts_limit(i_addr[5:2], i_wdata[15:0]);
                n.div_go = (i_addr[5:2] == `NTS_P_RATE);
            end
        end
        // Register reads, valid in the next cycle only
        if (i_rd)
        begin
            if (i_addr[7:6] == `NTS_A_PAR_WIN)
                n.rdata = {16'h0000, r.par[i_addr[5:2]]};
            else
                case (i_addr)
                    `NTS_A_CTRL:   n.rdata = {27'h0000000, r.ctrl};
                    `NTS_A_STATUS: n.rdata = {27'h0000000, r.mtt_hit,
                                              r.key, r.st};
                    `NTS_A_TURN:   n.rdata = {16'h0000, turn};
                    `NTS_A_TOLER:  n.rdata = {16'h0000, tol_eff};
                    `NTS_A_ACK:    n.rdata = {16'h0000, ack_eff};
                    `NTS_A_PROC:   n.rdata = {16'h0000, proc_eff};
                    `NTS_A_ABITS:  n.rdata = {16'h0000, ack_bits};
                    `NTS_A_AMS:    n.rdata = {16'h0000, r.quo};
                    `NTS_A_PHBITS: n.rdata = {16'h0000, r.phbits};
                    default:       n.rdata = 32'h00000000;
                endcase
        end

        // ack time by repeated subtraction
        // Slow but tiny; takes one cycle per unit of the quotient, plus one
        if (r.div_go)
        begin
            n.rem = ack_num;
            n.quo = 16'h0000;
            n.div_run = (r.par[`NTS_P_RATE] != 16'h0000);
        end
        else if (r.div_run)
        begin
            if (r.rem >= {8'h00, r.par[`NTS_P_RATE]})
            begin
                n.rem = r.rem - {8'h00, r.par[`NTS_P_RATE]};
                n.quo = r.quo + 16'h0001;
            end
            else
            begin
                n.div_run = 1'b0;
            end
        end

        // Transmit sequence
        unique case (r.st)
            nts_pkg::NTS_IDLE:
            begin
                if (i_tx_req && !r.busy2)
                begin
                    n.st = nts_pkg::NTS_TDLY;
                    n.ms_el = 16'h0000;
                end
            end
            nts_pkg::NTS_TDLY:
            begin
                if (r.ms_el >= r.par[`NTS_P_DTURN])
                begin
                    n.key = 1'b1;
                    n.st = nts_pkg::NTS_PRE;
                    n.ms_el = 16'h0000;
                    n.key_ms = 16'h0000;
                    n.mtt_hit = 1'b0;
                    n.phbits = 16'h0000;
                    n.phase_bit = 1'b1;
                end
            end
            nts_pkg::NTS_PRE:
            begin
                if (r.ms_el >= r.par[`NTS_P_PRE])
                begin
                    n.st = nts_pkg::NTS_PHASE;
                    n.ms_el = 16'h0000;
                end
            end
            nts_pkg::NTS_PHASE, nts_pkg::NTS_DATA:
            begin
                if (bit_en)
                begin
                    if (r.st == nts_pkg::NTS_PHASE && !phase_over)
                    begin
                        n.tx_bit = r.phase_bit;
                        n.phase_bit = ~r.phase_bit;
                        n.phbits = r.phbits + 16'h0001;
                    end
                    else
                    begin
                        n.tx_bit = i_tx_data;
                        n.take = 1'b1;
                        n.st = nts_pkg::NTS_DATA;
                        if (i_tx_last && !(i_tx_more && !mtt_over))
                        begin
                            n.st = nts_pkg::NTS_LAST;
                            n.mtt_hit = i_tx_more;
                        end
                    end
                end
            end
            nts_pkg::NTS_LAST:
            begin
                if (bit_en)
                begin
                    n.key = 1'b0;
                    n.tx_bit = 1'b1;
                    n.st = nts_pkg::NTS_LAG;
                    n.ms_el = 16'h0000;
                    n.lag_done = 1'b0;
                end
            end
            nts_pkg::NTS_LAG:
            begin
                if (!r.lag_done && r.ms_el >= r.par[`NTS_P_LAG])
                begin
                    n.lag_end = 1'b1;
                    n.lag_done = 1'b1;
                end
                else if (r.lag_done && r.ms_el >= turn_abs)
                begin
                    n.turn_end = 1'b1;
                    n.st = nts_pkg::NTS_IDLE;
                end
            end
        endcase

        if (r.clr)
        begin
            n.st = nts_pkg::NTS_IDLE;
            n.ms_cnt = 18'h00000;
            n.ms_el = 16'h0000;
            n.key_ms = 16'h0000;
            n.div_cnt = 16'h0000;
            n.key = 1'b0;
            n.tx_bit = 1'b1;
            n.lag_done = 1'b0;
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            r <= '0;
            r.st <= nts_pkg::NTS_IDLE;
            r.tx_bit <= 1'b1;
            r.ctrl <= `NTS_CTRL_RST;
            r.par <= {16{`NTS_PAR_RST}};
        end
        else
        begin
            r <= n;
        end
    end

    // hold delay and timeout from lag end
    nts_ms_timer u_hold (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_clr   (r.clr),
        .i_start (r.lag_end),
        .i_tick  (r.tick),
        .i_limit (r.par[`NTS_P_HOLD]),
        .o_run   (hold_run),
        .o_done  (o_hold_done)
    );
    nts_ms_timer u_tmo (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_clr   (r.clr),
        .i_start (r.lag_end),
        .i_tick  (r.tick),
        .i_limit (r.par[`NTS_P_TMO]),
        .o_run   (tmo_run),
        .o_done  (o_timeout_done)
    );
    // Access delay runs once the timeout has passed
    nts_ms_timer u_acc (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_clr   (r.clr),
        .i_start (o_timeout_done),
        .i_tick  (r.tick),
        .i_limit (r.par[`NTS_P_ACC]),
        .o_run   (),
        .o_done  (o_access_done)
    );

    // Outputs straight from the state register
    assign o_rdata    = r.rdata;
    assign o_tx_take  = r.take;
    assign o_key      = r.key;
    assign o_tx_bit   = r.tx_bit;
    assign o_lag_end  = r.lag_end;
    assign o_turn_end = r.turn_end;

    // Single-cycle pieces of the transmit sequence
    sequence ph_bit_s;
        r.st == nts_pkg::NTS_PHASE && bit_en && !phase_over;
    endsequence
    sequence ph_end_s;
        r.st == nts_pkg::NTS_PHASE && bit_en && phase_over && !r.clr;
    endsequence

    pre_quiet_a: assert property (
        r.st == nts_pkg::NTS_PRE |-> r.tx_bit && !r.take && r.key)
        else $error("line not idle during preamble");
    turn_delay_a: assert property (
        $rose(r.key) |-> $past(r.ms_el) >= $past(r.par[`NTS_P_DTURN]))
        else $error("keyed before terminal turnaround");
    phase_alt_a: assert property (
        ph_bit_s and !r.clr |=> r.tx_bit == $past(r.phase_bit) &&
                     r.phase_bit != $past(r.phase_bit))
        else $error("phasing bits not alternating");
    packet_zero_a: assert property (
        ph_end_s and r.ctrl[`NTS_C_PACKET] |=> r.take &&
                     r.phbits == 16'h0000)
        else $error("phasing sent in packet mode");
    data_follow_a: assert property (
        ph_end_s |=> r.take && r.st != nts_pkg::NTS_PHASE)
        else $error("gap between phasing and data");
    eot_a: assert property (
        r.st == nts_pkg::NTS_LAST && bit_en && !r.clr |=>
        !r.key && r.st == nts_pkg::NTS_LAG)
        else $error("end of transmission late");
    lag_end_a: assert property (
        r.lag_end && !r.clr |-> r.ms_el >= r.par[`NTS_P_LAG] ##1
        hold_run && tmo_run)
        else $error("access timers not started at lag end");
    tol_floor_a: assert property (
        tol_eff >= r.par[`NTS_P_TOLER] &&
        {1'b0, tol_eff} + r.par[`NTS_P_SMALL] >= r.par[`NTS_P_LAG])
        else $error("tolerance below lag difference");
    ack_time_a: assert property (
        $fell(r.div_run) && !$past(r.div_go) |->
        r.rem < {8'h00, r.par[`NTS_P_RATE]})
        else $error("ack time division incomplete");
    mtt_cut_a: assert property (
        $rose(r.mtt_hit) |-> r.st == nts_pkg::NTS_LAST && r.key &&
        r.key_ms >= r.par[`NTS_P_MAXTX])
        else $error("concatenation cut without limit");
    turn_end_a: assert property (
        r.turn_end |-> r.ms_el >= turn_abs && r.lag_done)
        else $error("turnaround ended early");
endmodule

// file: hdl/nts_map.svh
`ifndef NTS_MAP_SVH
`define NTS_MAP_SVH
// Clock period and millisecond base, in ns
`define NTS_CLK_NS      4
`define NTS_MS_NS       1000000
// Register byte addresses
`define NTS_A_CTRL      8'h00
`define NTS_A_STATUS    8'h04
`define NTS_A_TURN      8'h08
`define NTS_A_TOLER     8'h0C
`define NTS_A_ACK       8'h10
`define NTS_A_PROC      8'h14
`define NTS_A_ABITS     8'h18
`define NTS_A_AMS       8'h1C
`define NTS_A_PHBITS    8'h20
// Parameter window 0x40..0x7C, selected by address bits 7:6
`define NTS_A_PAR_WIN   2'h1
// Parameter slots inside the window
`define NTS_P_PRE       4'h0
`define NTS_P_PHASE     4'h1
`define NTS_P_LAG       4'h2
`define NTS_P_TXTURN    4'h3
`define NTS_P_RXTURN    4'h4
`define NTS_P_DTURN     4'h5
`define NTS_P_SMALL     4'h6
`define NTS_P_TOLER     4'h7
`define NTS_P_ACK       4'h8
`define NTS_P_PROC      4'h9
`define NTS_P_MAXTX     4'hA
`define NTS_P_BITDIV    4'hB
`define NTS_P_RATE      4'hC
`define NTS_P_HOLD      4'hD
`define NTS_P_TMO       4'hE
`define NTS_P_ACC       4'hF
// Control bit positions
`define NTS_C_SYNC      0
`define NTS_C_PACKET    1
`define NTS_C_FEC       2
`define NTS_C_DISP      3
`define NTS_C_IND       4
`define NTS_C_CLR       5
// Reset values
`define NTS_CTRL_RST    5'h00
`define NTS_PAR_RST     16'h0000
// Programming limits in ms
`define NTS_PRE_MAX     16'h7530
`define NTS_PHASE_MAX   16'h2710
`define NTS_DTURN_MAX   16'h0064
// Coupled acknowledgment field lengths in bits
`define NTS_SYNC_BITS   16'h0040
`define NTS_IND_BITS    16'h0040
`define NTS_HDR_BITS    16'h00A8
`define NTS_D_PLAIN     16'h0050
`define NTS_D_FEC       16'h00A8
`define NTS_D_BOTH      16'h0180
`define NTS_MS_PER_S    24'h0003E8
`endif

// file: hdl/nts_pkg.sv
package nts_pkg;
    // Transmit sequence phases
    typedef enum logic [2:0] {
        NTS_IDLE, NTS_TDLY, NTS_PRE, NTS_PHASE, NTS_DATA, NTS_LAST, NTS_LAG
    } nts_state_t;

    // State of the sequencer, apart from its three millisecond timers
    typedef struct packed {
        nts_state_t        st;
        logic              dclk1;
        logic              dclk2;
        logic              dclk_prev;
        logic              busy1;
        logic              busy2;
        logic [17:0]       ms_cnt;
        logic              tick;
        logic [15:0]       ms_el;
        logic [15:0]       key_ms;
        logic [15:0]       div_cnt;
        logic              phase_bit;
        logic [15:0]       phbits;
        logic              tx_bit;
        logic              take;
        logic              key;
        logic              lag_end;
        logic              lag_done;
        logic              turn_end;
        logic              mtt_hit;
        logic              clr;
        logic [4:0]        ctrl;
        logic [15:0][15:0] par;
        logic [31:0]       rdata;
        logic              div_go;
        logic              div_run;
        logic [23:0]       rem;
        logic [15:0]       quo;
    } nts_regs_t;

    // Millisecond timer state
    typedef struct packed {
        logic [15:0] cnt;
        logic        run;
        logic        done;
    } nts_tmr_t;
endpackage

// file: hdl/nts_ms_timer.sv
`timescale 1ns/1ps
module nts_ms_timer (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // Control
    input  wire logic        i_clr,
    input  wire logic        i_start,
    input  wire logic        i_tick,
    input  wire logic [15:0] i_limit,
    // Status
    output logic             o_run,
    output logic             o_done
);
    nts_pkg::nts_tmr_t r;
    nts_pkg::nts_tmr_t n;

    // Count ms ticks up to the limit, then pulse done
    always_comb
    begin
        n = r;
        n.done = 1'b0;
        if (i_clr)
        begin
            n = '0;
        end
        else if (i_start)
        begin
            n.run = 1'b1;
            n.cnt = 16'h0000;
        end
        else if (r.run)
        begin
            if (r.cnt >= i_limit)
            begin
                n.run = 1'b0;
                n.done = 1'b1;
            end
            else if (i_tick)
            begin
                n.cnt = r.cnt + 16'h0001;
            end
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            r <= '0;
        else
            r <= n;
    end

    assign o_run  = r.run;
    assign o_done = r.done;
endmodule

// file: test/nts_dce_model.sv
`timescale 1ns/1ps
module nts_dce_model #(
    parameter int PRE_NS = 400
) (
    // Terminal side
    input  wire logic i_key,
    input  wire logic i_tx_bit,
    // Equipment clock
    output logic      o_dce_clk
);
    logic [63:0] rx_bits;
    int          rx_cnt;
    // no clock while preamble runs
    // Clock rests low outside a keyed frame
    initial
    begin
        o_dce_clk = 1'b0;
        rx_bits = '0;
        rx_cnt = 0;
        forever
        begin
            @(posedge i_key);
            #(PRE_NS);
            while (i_key)
            begin
                #32 o_dce_clk = 1'b1;
                #32 o_dce_clk = 1'b0;
                // Late capture: the bit moves a few cycles after the edge
                if (i_key)
                begin
                    rx_bits = {rx_bits[62:0], i_tx_bit};
                    rx_cnt = rx_cnt + 1;
                end
            end
        end
    end
endmodule

// file: test/nts_sequencer_tb_top.sv
`timescale 1ns/1ps
module nts_sequencer_tb_top;
    logic        i_clk, i_rst_n, i_wr, i_rd, i_tx_req;
    logic        i_tx_more, i_net_busy;
    logic [7:0]  i_addr, frame;
    logic [31:0] i_wdata, o_rdata;
    logic        o_tx_take, o_key, o_tx_bit, o_lag_end, o_turn_end;
    logic        o_hold_done, o_timeout_done, o_access_done;
    logic [3:0]  idx;
    wire         i_dce_clk, i_tx_data, i_tx_last;
    int          n_fail, checks_done, takes, k, p, j;

    nts_sequencer #(.MS_CYCLES(80)) i_nts_sequencer (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_tx_req(i_tx_req), .i_tx_data(i_tx_data),
        .i_tx_last(i_tx_last), .i_tx_more(i_tx_more),
        .o_tx_take(o_tx_take), .i_dce_clk(i_dce_clk),
        .i_net_busy(i_net_busy), .o_key(o_key), .o_tx_bit(o_tx_bit),
        .o_lag_end(o_lag_end), .o_turn_end(o_turn_end),
        .o_hold_done(o_hold_done), .o_timeout_done(o_timeout_done),
        .o_access_done(o_access_done));
    nts_dce_model #(.PRE_NS(400)) i_nts_dce_model (
        .i_key(o_key), .i_tx_bit(o_tx_bit), .o_dce_clk(i_dce_clk));

    // Frame source, MSB first, advanced on each take
    assign i_tx_data = frame[3'h7 - idx[2:0]];
    assign i_tx_last = (idx == 4'h7);
    always @(posedge i_clk)
    begin
        if (o_tx_take)
        begin
            idx <= idx + 4'h1;
            takes <= takes + 1;
        end
    end

    initial
    begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 check(o_rdata, exp);
    endtask

    task automatic start_frame(input logic [7:0] f);
        frame = f;
        idx <= 4'h0;
        takes <= 0;
        @(posedge i_clk);
        i_tx_req <= 1'b1;
        for (k = 0; k < 9000 && o_key !== 1'b1; k++) @(posedge i_clk);
        i_tx_req <= 1'b0;
        #1 check(o_tx_bit, 1'b1);
        check(o_key, 1'b1);
    endtask

    task automatic wait_turn();
        for (k = 0; k < 20000 && o_turn_end !== 1'b1; k++)
            @(posedge i_clk);
        check(k < 20000, 1'b1);
    endtask

    task automatic t_regs();
        rd(8'h00, 32'h0);
        rd(8'h30, 32'h0);
        wr(8'h44, 32'h3000);
        rd(8'h44, 32'h2710);
        wr(8'h54, 32'hC8);
        rd(8'h54, 32'h64);
        wr(8'h40, 32'h9C40);
        rd(8'h40, 32'h7530);
        wr(8'h48, 32'h5);
        wr(8'h4C, 32'h8);
        wr(8'h50, 32'h9);
        wr(8'h58, 32'h2);
        wr(8'h5C, 32'h1);
        rd(8'h08, 32'h4);
        rd(8'h0C, 32'h3);
        rd(8'h10, 32'h4);
        rd(8'h14, 32'h4);
        for (j = 0; j < 8; j++)
        begin
            wr(8'h00, j << 2);
            p = 232 + (j[2] ? 64 : 0);
            p += j[0] ? (j[1] ? 384 : 168) : 80;
            rd(8'h18, p);
        end
        wr(8'h70, 32'h7D0);
        repeat (1000) @(posedge i_clk);
        rd(8'h1C, 32'h154);
        wr(8'h00, 32'h20);
        rd(8'h04, 32'h0);
    endtask

    task automatic t_sync();
        wr(8'h40, 32'h1);
        wr(8'h44, 32'h2);
        wr(8'h54, 32'h0);
        wr(8'h00, 32'h1);
        start_frame(8'hA5);
        wait_turn();
        p = i_nts_dce_model.rx_cnt - 8;
        check(i_nts_dce_model.rx_bits[7:0], 8'hA5);
        check(takes, 8);
        check(p >= 4 && p <= 11, 1'b1);
        rd(8'h20, p);
        for (j = 0; j < p; j++)
            check(i_nts_dce_model.rx_bits[7 + p - j],
                  j[0] ? 32'h0 : 32'h1);
    endtask

    task automatic t_async();
        wr(8'h00, 32'h2);
        wr(8'h6C, 32'h63);
        wr(8'h68, 32'h1);
        i_tx_more <= 1'b1;
        i_net_busy <= 1'b1;
        // Busy must be through its synchroniser before the request
        repeat (3) @(posedge i_clk);
        i_tx_req <= 1'b1;
        repeat (50) @(posedge i_clk);
        #1 check(o_key, 1'b0);
        @(posedge i_clk);
        i_net_busy <= 1'b0;
        start_frame(8'h3C);
        for (k = 0; k < 9000 && o_lag_end !== 1'b1; k++)
            @(posedge i_clk);
        check(k < 9000, 1'b1);
        #1 k = 0;
        for (j = 0; j < 9 && o_hold_done !== 1'b1; j++)
        begin
            @(posedge i_clk);
            #1 k++;
        end
        check(k, 1);
        check(o_timeout_done, 1'b1);
        repeat (2) @(posedge i_clk);
        #1 check(o_access_done, 1'b1);
        wait_turn();
        check(takes, 8);
        rd(8'h20, 32'h0);
        rd(8'h04, 32'h10);
    endtask

    task automatic finish_test();
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        #300000;
        n_fail++;
        finish_test();
    end

    initial
    begin
        {i_rst_n, i_wr, i_rd, i_tx_req, i_tx_more, i_net_busy} = '0;
        i_addr = '0;
        i_wdata = '0;
        frame = '0;
        idx = '0;
        {n_fail, checks_done, takes} = '0;
        repeat (8) @(posedge i_clk);
        check({o_key, o_tx_bit}, 2'b01);
        i_rst_n <= 1'b1;
        t_regs();
        t_sync();
        t_async();
        finish_test();
    end
endmodule
